// File: core/ipic_top.sv
// interrupt priority controller with idle and power-down control
// Functional notes
// - eight request sources arbitrated over four priority levels
// - serial and spi share one request and vector 0023H
// - equal level: ext0, brownout, t0, ext1, t1, pca, serial, t2
// - fixed vector per source; brownout has its own flag at bit 1
// - enable bit 7 gates all servicing globally
// - main enable bits 6..0 per source enables
// - brownout enable at bit 3 of second enable register
// - low priority bits 6..0 in enable register order
// - high priority bits 6..0 in the same order
// - brownout low/high priority at bit 4 of two registers
// - six registers reset to 00H; bit access is a cpu matter
// - idle bit halts the program counter
// - clock and all interrupt sources keep running in idle
// - registers keep contents during idle
// - start of interrupt service clears the idle bit
// - only enabled level external interrupts end power-down
`timescale 1ns/100ps
`default_nettype none

module ipic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] src_flag,
  input wire logic [1:0] ext_level_mode,
  input wire ipic_pkg::ipic_cpu_in_t cpu_in,
  output ipic_pkg::ipic_irq_out_t irq_out,
  output logic pc_halt,
  output logic clk_stop
);

  logic [7:0] en_main_q;
  logic [7:0] ph_main_q;
  logic [7:0] pl_main_q;
  logic [7:0] en_bo_q;
  logic [7:0] ph_bo_q;
  logic [7:0] pl_bo_q;
  logic idle_q;
  logic pd_q;
  logic [3:0] in_svc_q;
  logic [3:0] in_svc_d;
  ipic_pkg::ipic_irq_out_t irq_q;
  ipic_pkg::ipic_irq_out_t irq_d;

  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] dph_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [31:0] rd_d;
  logic addr_take;

  logic [7:0] elig;
  logic [7:0][1:0] lvl;
  logic [7:0] wake_src;
  logic win_ok;
  logic [2:0] win_idx;
  logic [1:0] win_lvl;
  logic act_any;
  logic [1:0] act_lvl;
  logic preempt_ok;
  logic wake;
  logic gate;

  assign gate = en_main_q[ipic_pkg::GATE_BIT];

  // per-source eligibility and level
  for (genvar s = 0; s < 8; s++) begin : g_src
    logic en_s;
    logic hi_s;
    logic lo_s;
    if (s == int'(ipic_pkg::SRC_BO)) begin : g_bo
      assign en_s = en_bo_q[ipic_pkg::BO_EN_BIT];
      assign hi_s = ph_bo_q[ipic_pkg::BO_PRIO_BIT];
      assign lo_s = pl_bo_q[ipic_pkg::BO_PRIO_BIT];
    end else begin : g_main
      assign en_s = en_main_q[ipic_pkg::SRC_BIT[s]];
      assign hi_s = ph_main_q[ipic_pkg::SRC_BIT[s]];
      assign lo_s = pl_main_q[ipic_pkg::SRC_BIT[s]];
    end
    assign lvl[s] = {hi_s, lo_s};
    if (s == int'(ipic_pkg::SRC_EXT0)) begin : g_w0
      assign wake_src[s] = ext_level_mode[0];
    end else if (s == int'(ipic_pkg::SRC_EXT1)) begin : g_w1
      assign wake_src[s] = ext_level_mode[1];
    end else begin : g_wn
      assign wake_src[s] = 1'b0;
    end
    // flag, own enable and gate; only wakers in power-down
    assign elig[s] = src_flag[s] & en_s & gate & (~pd_q | wake_src[s]);
  end

  // power-down ends on enabled level external request
  assign wake = pd_q & |(elig & wake_src);

  always_comb begin
    win_ok = 1'b0;
    win_idx = 3'h0;
    win_lvl = 2'h0;
    // walk backwards so the earliest poll slot wins a tie
    for (int i = 7; i >= 0; i--) begin
      if (elig[i] && (!win_ok || lvl[i] >= win_lvl)) begin
        win_ok = 1'b1;
        win_idx = 3'(i);
        win_lvl = lvl[i];
      end
    end
  end

  // highest level currently in service
  always_comb begin
    act_any = |in_svc_q;
    act_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_svc_q[l]) begin
        act_lvl = 2'(l);
      end
    end
  end

  assign preempt_ok = win_ok && (!act_any || win_lvl > act_lvl);

  // request drops in the ack cycle to avoid a stale repeat
  always_comb begin
    irq_d.req = preempt_ok & ~(cpu_in.ack & irq_q.req);
    irq_d.level = win_lvl;
    irq_d.src = win_idx;
    // fixed vector table, serial and spi share one slot
    irq_d.vector = ipic_pkg::SRC_VEC[win_idx];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= '0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // reti retires the top level, ack then books the taken one
  always_comb begin
    in_svc_d = in_svc_q;
    if (cpu_in.reti && act_any) begin
      in_svc_d[act_lvl] = 1'b0;
    end
    if (cpu_in.ack && irq_q.req) begin
      in_svc_d[irq_q.level] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_svc_q <= 4'h0;
    end else begin
      in_svc_q <= in_svc_d;
    end
  end

  // bus address phase
  assign addr_take = hsel & hready & (htrans == ipic_pkg::HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dph_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_take & hwrite;
      rd_pend_q <= addr_take & ~hwrite;
      if (addr_take) begin
        dph_addr_q <= haddr[11:0];
      end
    end
  end

  // one wait state on reads while the registered read data is loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= ~(addr_take & ~hwrite);
    end
  end

  // reserved bits are masked on write and read back zero
  // all six reset to zero; nothing here depends on idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_main_q <= ipic_pkg::REG_RST;
      ph_main_q <= ipic_pkg::REG_RST;
      pl_main_q <= ipic_pkg::REG_RST;
      en_bo_q <= ipic_pkg::REG_RST;
      ph_bo_q <= ipic_pkg::REG_RST;
      pl_bo_q <= ipic_pkg::REG_RST;
    end else if (wr_pend_q) begin
      case (dph_addr_q)
        {2'h0, ipic_pkg::IDX_EN_MAIN, 2'h0}: begin
          en_main_q <= hwdata[7:0];
        end
        {2'h0, ipic_pkg::IDX_PH_MAIN, 2'h0}: begin
          ph_main_q <= hwdata[7:0] & ipic_pkg::MAIN_MASK;
        end
        {2'h0, ipic_pkg::IDX_PL_MAIN, 2'h0}: begin
          pl_main_q <= hwdata[7:0] & ipic_pkg::MAIN_MASK;
        end
        {2'h0, ipic_pkg::IDX_EN_BO, 2'h0}: begin
          en_bo_q <= {4'h0, hwdata[ipic_pkg::BO_EN_BIT], 3'h0};
        end
        {2'h0, ipic_pkg::IDX_PH_BO, 2'h0}: begin
          ph_bo_q <= {3'h0, hwdata[ipic_pkg::BO_PRIO_BIT], 4'h0};
        end
        {2'h0, ipic_pkg::IDX_PL_BO, 2'h0}: begin
          pl_bo_q <= {3'h0, hwdata[ipic_pkg::BO_PRIO_BIT], 4'h0};
        end
        default: begin
        end
      endcase
    end
  end

  // software set wins over the hardware clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      if (cpu_in.ack && irq_q.req) begin
        idle_q <= 1'b0;
      end
      if (wake) begin
        pd_q <= 1'b0;
      end
      if (wr_pend_q && dph_addr_q == {2'h0, ipic_pkg::IDX_PWR, 2'h0}) begin
        // idle request halts the program counter
        if (hwdata[ipic_pkg::PWR_IDLE_BIT]) begin
          idle_q <= 1'b1;
        end
        if (hwdata[ipic_pkg::PWR_PD_BIT]) begin
          pd_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (dph_addr_q)
      {2'h0, ipic_pkg::IDX_EN_MAIN, 2'h0}: rd_d[7:0] = en_main_q;
      {2'h0, ipic_pkg::IDX_PH_MAIN, 2'h0}: rd_d[7:0] = ph_main_q;
      {2'h0, ipic_pkg::IDX_PL_MAIN, 2'h0}: rd_d[7:0] = pl_main_q;
      {2'h0, ipic_pkg::IDX_EN_BO, 2'h0}: rd_d[7:0] = en_bo_q;
      {2'h0, ipic_pkg::IDX_PH_BO, 2'h0}: rd_d[7:0] = ph_bo_q;
      {2'h0, ipic_pkg::IDX_PL_BO, 2'h0}: rd_d[7:0] = pl_bo_q;
      {2'h0, ipic_pkg::IDX_PWR, 2'h0}: rd_d[1:0] = {pd_q, idle_q};
      {2'h0, ipic_pkg::IDX_STAT, 2'h0}: begin
        rd_d[3:0] = in_svc_q;
        rd_d[4] = irq_q.req;
        rd_d[6:5] = irq_q.level;
        rd_d[10:8] = irq_q.src;
        rd_d[31:16] = irq_q.vector;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_d;
    end
  end

  // clock keeps running in idle; only pc halts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_halt <= 1'b0;
      clk_stop <= 1'b0;
    end else begin
      pc_halt <= (idle_q | pd_q) & ~(cpu_in.ack & irq_q.req) & ~wake;
      clk_stop <= pd_q & ~wake;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign irq_out = irq_q;

endmodule : ipic_top

`default_nettype wire

// File: core/ipic_pkg.sv
// shared constants and carrier types for the interrupt priority controller
package ipic_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_EN_MAIN = 8'ha8;
  localparam logic [7:0] IDX_PH_MAIN = 8'hb7;
  localparam logic [7:0] IDX_PL_MAIN = 8'hb8;
  localparam logic [7:0] IDX_EN_BO = 8'he8;
  localparam logic [7:0] IDX_PH_BO = 8'hf7;
  localparam logic [7:0] IDX_PL_BO = 8'hf8;
  localparam logic [7:0] IDX_PWR = 8'h87;
  localparam logic [7:0] IDX_STAT = 8'h90;

  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] MAIN_MASK = 8'h7f;
  localparam int GATE_BIT = 7;
  localparam int BO_EN_BIT = 3;
  localparam int BO_PRIO_BIT = 4;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_PD_BIT = 1;

  // sources in polling order, index 0 polled first
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_BO = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h3;

  // enable/priority bit of each source in the main registers
  localparam logic [7:0][2:0] SRC_BIT = {
    3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};

  localparam logic [7:0][15:0] SRC_VEC = {
    16'h002b, 16'h0023, 16'h0033, 16'h001b,
    16'h0013, 16'h000b, 16'h004b, 16'h0003};

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic ack;
    logic reti;
  } ipic_cpu_in_t;

  typedef struct packed {
    logic req;
    logic [1:0] level;
    logic [2:0] src;
    logic [15:0] vector;
  } ipic_irq_out_t;

endpackage : ipic_pkg

// File: sim/ipic_top_assertions.sv
// port checker for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
module ipic_top_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [7:0] src_flag,
  input wire ipic_pkg::ipic_cpu_in_t cpu_in,
  input wire ipic_pkg::ipic_irq_out_t irq_out,
  input wire logic pc_halt,
  input wire logic clk_stop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] flag_q;
  logic go;
  assign go = hsel && hready && htrans == ipic_pkg::HTRANS_NONSEQ;
  // no reset: only compared once reset is gone
  always_ff @(posedge hclk) begin
    flag_q <= src_flag;
  end
  AST_RD_WAIT:
    assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  AST_REQ_FLAG:
    assert property (irq_out.req |-> flag_q[irq_out.src])
    else $error("request without flag");
  AST_VEC:
    assert property (irq_out.req |->
      irq_out.vector == ipic_pkg::SRC_VEC[irq_out.src])
    else $error("wrong vector");
  AST_ACK_DROP:
    assert property (cpu_in.ack && irq_out.req |=> !irq_out.req)
    else $error("request held after ack");
  AST_WAKE:
    assert property (cpu_in.ack && irq_out.req && !clk_stop |=> !pc_halt)
    else $error("idle kept after ack");
  AST_PD_HALT:
    assert property (clk_stop |-> pc_halt)
    else $error("power-down without halt");
  AST_PD_MASK:
    assert property (clk_stop [*3] ##0 irq_out.req |->
      irq_out.src inside {ipic_pkg::SRC_EXT0, ipic_pkg::SRC_EXT1})
    else $error("non-waking source in power-down");
  AST_IDLE_LIVE:
    assert property (pc_halt && !clk_stop && irq_out.req && !cpu_in.ack
      && src_flag == flag_q |=> irq_out.req)
    else $error("request lost in idle");
endmodule : ipic_top_assertions
bind ipic_top ipic_top_assertions u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .src_flag, .cpu_in, .irq_out, .pc_halt,
  .clk_stop);
`default_nettype wire

// File: sim/ipic_cpu_model.sv
// cpu sequencer model: takes presented requests, returns from service
`timescale 1ns/100ps
`default_nettype none
module ipic_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ipic_pkg::ipic_irq_out_t irq_out,
  input wire logic auto_ack,
  input wire logic [3:0] ack_delay,
  input wire logic reti_req,
  output ipic_pkg::ipic_cpu_in_t cpu_in
);
  logic [3:0] wait_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 4'h0;
      cpu_in <= '0;
    end else begin
      cpu_in.reti <= reti_req;
      // ack starts service, slow when delayed
      cpu_in.ack <= auto_ack && irq_out.req && !cpu_in.ack
        && wait_q >= ack_delay;
      wait_q <= (irq_out.req && !cpu_in.ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : ipic_cpu_model
`default_nettype wire

// File: sim/irq_priority_idle_ctrl_test.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module irq_priority_idle_ctrl_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] src_flag = 8'h00;
  logic [1:0] ext_level_mode = 2'h0;
  logic auto_ack = 1'b0;
  logic [3:0] ack_delay = 4'h3;
  logic reti_req = 1'b0;
  ipic_pkg::ipic_cpu_in_t cpu_in;
  ipic_pkg::ipic_irq_out_t irq_out;
  logic pc_halt;
  logic clk_stop;
  logic [31:0] rdv;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] vec [8] = '{16'h0003, 16'h004b, 16'h000b, 16'h0013,
    16'h001b, 16'h0033, 16'h0023, 16'h002b};
  logic [7:0] idx [6] = '{8'ha8, 8'hb7, 8'hb8, 8'he8, 8'hf7, 8'hf8};
  logic [7:0] msk [6] = '{8'hff, 8'h7f, 8'h7f, 8'h08, 8'h10, 8'h10};
  always #5 hclk = ~hclk;
  ipic_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .src_flag, .ext_level_mode, .cpu_in, .irq_out, .pc_halt,
    .clk_stop);
  ipic_cpu_model u_cpu (.hclk, .hresetn, .irq_out, .auto_ack, .ack_delay,
    .reti_req, .cpu_in);
  task automatic xfer(input logic wr, input logic [7:0] ix,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= ipic_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h00_0000, ix, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : xfer
  task automatic irq(input logic [7:0] f, input int n);
    src_flag <= f;
    repeat (n) @(posedge hclk);
  endtask : irq
  task automatic reti();
    irq(8'h00, 1);
    reti_req <= 1'b1;
    repeat (3) @(posedge hclk);
    reti_req <= 1'b0;
    @(posedge hclk);
  endtask : reti
  task end_of_test();
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // hang guard, the whole run needs far fewer cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (idx[i]) begin
      xfer(1'b0, idx[i], 32'h0000_0000);
      `CHK(rdv, 32'h0000_0000)
      xfer(1'b1, idx[i], 32'hffff_ffff);
      xfer(1'b0, idx[i], 32'h0000_0000);
      `CHK(rdv, {24'h00_0000, msk[i]})
      xfer(1'b1, idx[i], (i == 0 || i == 3) ? 32'h0000_00ff : 32'h0);
    end
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    for (int i = 0; i < 8; i++) begin
      irq(8'hff << i, 3);
      `CHK({irq_out.req, irq_out.src}, {1'b1, 3'(i)})
      `CHK(irq_out.vector, vec[i])
    end
    xfer(1'b1, 8'ha8, 32'h0000_007f);
    irq(8'h01, 3);
    `CHK(irq_out.req, 1'b0)
    xfer(1'b1, 8'ha8, 32'h0000_00fe);
    irq(8'h05, 3);
    `CHK(irq_out.src, 3'h2)
    xfer(1'b1, 8'ha8, 32'h0000_00ff);
    xfer(1'b1, 8'hb7, 32'h0000_0020);
    xfer(1'b1, 8'hb8, 32'h0000_0020);
    irq(8'hff, 3);
    `CHK({irq_out.src, irq_out.level}, 5'h1f)
    xfer(1'b1, 8'hb8, 32'h0000_0000);
    // register lands at the write edge, request one edge later
    irq(8'hff, 2);
    `CHK({irq_out.src, irq_out.level}, 5'h1e)
    xfer(1'b1, 8'hf7, 32'h0000_0010);
    xfer(1'b1, 8'hf8, 32'h0000_0010);
    irq(8'hff, 2);
    `CHK({irq_out.src, irq_out.level}, 5'h07)
    // equal and lower wait, higher preempts
    auto_ack <= 1'b1;
    irq(8'h80, 10);
    auto_ack <= 1'b0;
    irq(8'h81, 3);
    `CHK(irq_out.req, 1'b0)
    irq(8'h83, 3);
    `CHK({irq_out.req, irq_out.src}, 4'h9)
    xfer(1'b0, 8'h90, 32'h0000_0000);
    `CHK(rdv, 32'h004b_0174)
    reti();
    reti();
    xfer(1'b1, 8'h87, 32'h0000_0001);
    irq(8'h00, 2);
    `CHK({pc_halt, clk_stop}, 2'h2)
    xfer(1'b0, 8'hb7, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0020)
    auto_ack <= 1'b1;
    irq(8'h04, 10);
    `CHK(pc_halt, 1'b0)
    reti();
    // only enabled level external sources wake power-down
    auto_ack <= 1'b0;
    ack_delay <= 4'h0;
    ext_level_mode <= 2'h1;
    xfer(1'b1, 8'h87, 32'h0000_0002);
    irq(8'h00, 2);
    `CHK({pc_halt, clk_stop}, 2'h3)
    irq(8'h1c, 4);
    `CHK(irq_out.req, 1'b0)
    irq(8'h1d, 3);
    `CHK({irq_out.req, irq_out.src}, 4'h8)
    auto_ack <= 1'b1;
    irq(8'h1d, 6);
    `CHK({pc_halt, clk_stop}, 2'h0)
    end_of_test();
  end
endmodule : irq_priority_idle_ctrl_test
`default_nettype wire
